/* pkg/ee_ctl_consts.svh */
// Address map, field positions, reset values and timing constants of the EEPROM controller.
`ifndef EE_CTL_CONSTS_SVH
`define EE_CTL_CONSTS_SVH
// ****************************************************************
// Address map
// ****************************************************************
`define ARRAY_FIRST 16'h0800
`define ARRAY_LAST 16'h09FF
`define PERM_FIRST 16'h08F0
`define PERM_LAST 16'h08FF
`define CTRL_ADDR 16'h0A00
`define NV_ADDR 16'h0A01
`define SHADOW_ADDR 16'h0A02
`define ARRAY_WORDS 512
`define BLOCK_COUNT 4
`define BLK_HI 8
`define BLK_LO 7
// ****************************************************************
// Control register fields
// ****************************************************************
`define CTRL_LAT 0
`define CTRL_PGM 1
`define CTRL_RAS_LO 2
`define CTRL_RAS_HI 3
`define CTRL_AUTO 4
// ****************************************************************
// Nonvolatile configuration byte fields and values
// ****************************************************************
`define NV_BP_HI 3
`define NV_BP_LO 0
`define NV_PERM 7
`define ERASED_BYTE 8'hFF
`define NV_FACTORY 8'h70
`define ZERO_BYTE 8'h00
// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS 10
`define BYTE_OP_TIME_US 10
`define BLOCK_ERASE_TIME_US 20
`define BULK_ERASE_TIME_US 50
`define VOLTAGE_FALL_TIME_US 2
`define BYTE_TICKS 16'h0100
`define BLOCK_TICKS 16'h0200
`define BULK_TICKS 16'h0400
`endif

/* pkg/ee_ctl_pkg.sv */
// Operation code shared by both ends of the EEPROM program/erase link, and the sequencer states.
package ee_ctl_pkg;
   typedef enum logic [1:0] {
      OP_PROG = 2'h0,
      OP_BYTE_ERASE = 2'h1,
      OP_BLOCK_ERASE = 2'h2,
      OP_BULK_ERASE = 2'h3
   } op_t;
   typedef enum logic [10:0] {
      S_IDLE = 11'h001,
      S_SETUP = 11'h002,
      S_DATA = 11'h004,
      S_PGM_ON = 11'h008,
      S_WAIT_OP = 11'h010,
      S_PGM_OFF = 11'h020,
      S_WAIT_FALL = 11'h040,
      S_LAT_OFF = 11'h080,
      S_POLL = 11'h100,
      S_POLL_CHK = 11'h200,
      S_READ = 11'h400
   } host_state_t;
endpackage

/* pkg/ee_bus_if.sv */
// CPU bus between the program/erase sequencer and the EEPROM controller.
`timescale 1ns/10ps
interface ee_bus_if (
   input wire logic ref_clk
);
   logic wr_en;
   logic rd_en;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport dev (input wr_en, input rd_en, input addr, input wdata, output rdata);
   modport host (output wr_en, output rd_en, output addr, output wdata, input rdata);
endinterface

/* core/ee_array_ctl.sv */
// EEPROM array with its program/erase control, protection and configuration shadow.
`timescale 1ns/10ps
`include "ee_ctl_consts.svh"
module ee_array_ctl #(
   parameter logic [15:0] BYTE_TICKS = `BYTE_TICKS,
   parameter logic [15:0] BLOCK_TICKS = `BLOCK_TICKS,
   parameter logic [15:0] BULK_TICKS = `BULK_TICKS
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   ee_bus_if.dev bus,
   input wire logic timebase_tick,
   output logic charge_pump_en,
   output logic array_hv,
   output logic [7:0] config_shadow,
   output logic perm_armed
);
   // ****************************************************************
   // State
   // ****************************************************************
   // Nonvolatile contents survive reset, so they start from the erased state
   // plus the factory configuration value rather than from a reset branch.
   logic [7:0] mem [0:`ARRAY_WORDS-1] = '{default: `ERASED_BYTE};
   logic [7:0] nv_config_byte = `NV_FACTORY;
   logic program_latch_bit;
   logic high_voltage_enable;
   logic erase_select_hi;
   logic erase_select_lo;
   logic auto_mode;
   logic captured;
   logic [15:0] lat_addr;
   logic [7:0] lat_data;
   logic [15:0] tick_cnt;
   logic load_pending;
   logic [7:0] rdata;

   // ****************************************************************
   // Address decode
   // ****************************************************************
   wire is_array = (bus.addr >= `ARRAY_FIRST) && (bus.addr <= `ARRAY_LAST);
   wire is_nv = bus.addr == `NV_ADDR;
   wire is_ctrl = bus.addr == `CTRL_ADDR;
   wire is_shadow = bus.addr == `SHADOW_ADDR;
   wire valid_tgt = is_array || is_nv;
   wire [15:0] arr_off = bus.addr - `ARRAY_FIRST;
   wire [15:0] lat_off = lat_addr - `ARRAY_FIRST;
   wire [1:0] lat_blk = lat_off[`BLK_HI:`BLK_LO];
   wire lat_is_nv = lat_addr == `NV_ADDR;
   wire [7:0] ctrl_value = {3'h0, auto_mode, erase_select_hi, erase_select_lo,
                            high_voltage_enable, program_latch_bit};

   // ****************************************************************
   // Control register write
   // ****************************************************************
   wire ctrl_wr = bus.wr_en && is_ctrl && !(program_latch_bit && !captured);
   wire w_lat = bus.wdata[`CTRL_LAT];
   wire w_pgm = bus.wdata[`CTRL_PGM];
   wire pgm_allowed = (program_latch_bit && captured) || high_voltage_enable;
   wire [1:0] op_sel = {erase_select_hi, erase_select_lo};
   wire [15:0] op_ticks = (op_sel == ee_ctl_pkg::OP_BULK_ERASE) ? BULK_TICKS :
                          (op_sel == ee_ctl_pkg::OP_BLOCK_ERASE) ? BLOCK_TICKS : BYTE_TICKS;
   // The self-timed end precedes the voltage fall time by construction; the
   // tick counts are fixed per operation so the delay is always that many timebase ticks.
   wire auto_done = high_voltage_enable && auto_mode && timebase_tick &&
                    (tick_cnt == op_ticks - 16'h0001);
   wire pgm_cleared = high_voltage_enable && (auto_done || (ctrl_wr && !w_pgm));
   wire next_pgm = ctrl_wr ? (w_pgm && pgm_allowed && !auto_done) :
                   (high_voltage_enable && !auto_done);
   // The latch cannot drop while voltage is on, so a write clearing both
   // bits only takes the voltage away.
   wire next_lat = ctrl_wr ? (w_lat || high_voltage_enable) : program_latch_bit;
   wire arr_capture = bus.wr_en && valid_tgt && program_latch_bit;

   // ****************************************************************
   // Protection and operation selection
   // ****************************************************************
   wire [3:0] bp = config_shadow[`NV_BP_HI:`NV_BP_LO];
   wire in_perm = (lat_addr >= `PERM_FIRST) && (lat_addr <= `PERM_LAST);
   wire is_wide = (op_sel == ee_ctl_pkg::OP_BLOCK_ERASE) ||
                  (op_sel == ee_ctl_pkg::OP_BULK_ERASE);
   wire blocked = (in_perm && perm_armed) ||
                  (lat_is_nv && perm_armed) ||
                  (is_wide && perm_armed) ||
                  ((op_sel == ee_ctl_pkg::OP_BULK_ERASE) && (bp != 4'h0)) ||
                  (!lat_is_nv && bp[lat_blk]);
   wire hv_live = high_voltage_enable && !blocked;
   wire apply = hv_live && pgm_cleared;
   wire prog_op = op_sel == ee_ctl_pkg::OP_PROG;

   assign charge_pump_en = high_voltage_enable;
   assign array_hv = hv_live;
   assign bus.rdata = rdata;

   // ****************************************************************
   // Per-entry erase and program selection
   // ****************************************************************
   logic [`ARRAY_WORDS-1:0] erase_hit;
   logic [`ARRAY_WORDS-1:0] prog_hit;
   genvar gi;
   generate
      for (gi = 0; gi < `ARRAY_WORDS; gi++) begin : g_entry
         localparam logic [8:0] IDX = 9'(gi);
         wire own = !lat_is_nv && (lat_off[8:0] == IDX);
         assign erase_hit[gi] = apply && (
            ((op_sel == ee_ctl_pkg::OP_BYTE_ERASE) && own) ||
            ((op_sel == ee_ctl_pkg::OP_BLOCK_ERASE) && (IDX[`BLK_HI:`BLK_LO] == lat_blk)) ||
            (op_sel == ee_ctl_pkg::OP_BULK_ERASE));
         assign prog_hit[gi] = apply && prog_op && own;
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < `ARRAY_WORDS; i++) begin
         if (erase_hit[i]) begin
            mem[i] <= `ERASED_BYTE;
         end else if (prog_hit[i]) begin
            mem[i] <= mem[i] & lat_data;
         end
      end
   end

   // Only byte-level operations aimed at the configuration address reach it.
   always_ff @(posedge ref_clk) begin
      if (apply && lat_is_nv && prog_op) begin
         nv_config_byte <= nv_config_byte & lat_data;
      end else if (apply && lat_is_nv && (op_sel == ee_ctl_pkg::OP_BYTE_ERASE)) begin
         nv_config_byte <= `ERASED_BYTE;
      end
   end

   // ****************************************************************
   // Control, latch and timer
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         program_latch_bit <= 1'b0;
         high_voltage_enable <= 1'b0;
         erase_select_hi <= 1'b0;
         erase_select_lo <= 1'b0;
         auto_mode <= 1'b0;
      end else begin
         program_latch_bit <= next_lat;
         high_voltage_enable <= next_pgm;
         if (ctrl_wr && !high_voltage_enable) begin
            erase_select_hi <= bus.wdata[`CTRL_RAS_HI];
            erase_select_lo <= bus.wdata[`CTRL_RAS_LO];
            auto_mode <= bus.wdata[`CTRL_AUTO];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n || !next_lat || (ctrl_wr && !program_latch_bit)) begin
         captured <= 1'b0;
         lat_addr <= 16'h0000;
         lat_data <= `ZERO_BYTE;
      end else if (arr_capture) begin
         captured <= 1'b1;
         lat_addr <= bus.addr;
         lat_data <= bus.wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n || !high_voltage_enable || auto_done) begin
         tick_cnt <= 16'h0000;
      end else if (timebase_tick && auto_mode) begin
         tick_cnt <= tick_cnt + 16'h0001;
      end
   end

   // ****************************************************************
   // Read path, shadow and permanent protection
   // ****************************************************************
   wire nv_read = bus.rd_en && is_nv && !program_latch_bit;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rdata <= `ZERO_BYTE;
      end else if (bus.rd_en) begin
         if (is_ctrl) begin
            rdata <= ctrl_value;
         end else if (is_shadow) begin
            rdata <= config_shadow;
         end else if (valid_tgt && program_latch_bit) begin
            rdata <= lat_data;
         end else if (is_nv) begin
            rdata <= nv_config_byte;
         end else if (is_array) begin
            rdata <= mem[arr_off[8:0]];
         end else begin
            rdata <= `ZERO_BYTE;
         end
      end
   end

   // The reset load is deferred one cycle because the source is storage,
   // not a constant.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         load_pending <= 1'b1;
         config_shadow <= `ZERO_BYTE;
         perm_armed <= 1'b0;
      end else begin
         load_pending <= 1'b0;
         if (load_pending || nv_read) begin
            config_shadow <= nv_config_byte;
         end
         perm_armed <= perm_armed || !nv_config_byte[`NV_PERM];
      end
   end
endmodule

/* core/ee_seq_host.sv */
// Bus master that runs the program, erase and read sequences on the EEPROM controller.
`timescale 1ns/10ps
`include "ee_ctl_consts.svh"
module ee_seq_host #(
   parameter logic [23:0] BYTE_OP_CYC = 24'(`BYTE_OP_TIME_US * 1000 / `CLK_PERIOD_NS),
   parameter logic [23:0] BLOCK_CYC = 24'(`BLOCK_ERASE_TIME_US * 1000 / `CLK_PERIOD_NS),
   parameter logic [23:0] BULK_CYC = 24'(`BULK_ERASE_TIME_US * 1000 / `CLK_PERIOD_NS),
   parameter logic [23:0] FALL_CYC = 24'((`VOLTAGE_FALL_TIME_US * 1000 + `CLK_PERIOD_NS - 1)
                                         / `CLK_PERIOD_NS)
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   ee_bus_if.host bus,
   input wire logic req_valid,
   input wire logic req_write,
   input wire ee_ctl_pkg::op_t req_op,
   input wire logic req_auto,
   input wire logic [15:0] req_addr,
   input wire logic [7:0] req_data,
   output logic req_ready,
   output logic resp_valid,
   output logic [7:0] resp_data
);
   // ****************************************************************
   // Sequencer
   // ****************************************************************
   ee_ctl_pkg::host_state_t state;
   ee_ctl_pkg::host_state_t next_state;
   ee_ctl_pkg::op_t op;
   logic use_auto;
   logic [15:0] tgt_addr;
   logic [7:0] tgt_data;
   logic [23:0] wait_cnt;
   logic wr_en;
   logic rd_en;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic rd_wait;

   wire [23:0] op_cyc = (op == ee_ctl_pkg::OP_BULK_ERASE) ? BULK_CYC :
                        (op == ee_ctl_pkg::OP_BLOCK_ERASE) ? BLOCK_CYC : BYTE_OP_CYC;
   wire wait_end = wait_cnt == 24'h000001;
   wire [7:0] ctrl_base = 8'(({7'h00, use_auto} << `CTRL_AUTO) | ({6'h00, op} << `CTRL_RAS_LO));
   wire [7:0] lat_bit = 8'h01 << `CTRL_LAT;
   wire [7:0] pgm_bit = 8'h01 << `CTRL_PGM;

   assign req_ready = state == ee_ctl_pkg::S_IDLE;
   assign bus.wr_en = wr_en;
   assign bus.rd_en = rd_en;
   assign bus.addr = addr;
   assign bus.wdata = wdata;

   always_comb begin
      next_state = state;
      case (state)
         ee_ctl_pkg::S_IDLE: begin
            if (req_valid) begin
               next_state = req_write ? ee_ctl_pkg::S_SETUP : ee_ctl_pkg::S_READ;
            end
         end
         ee_ctl_pkg::S_SETUP: next_state = ee_ctl_pkg::S_DATA;
         ee_ctl_pkg::S_DATA: next_state = ee_ctl_pkg::S_PGM_ON;
         ee_ctl_pkg::S_PGM_ON: begin
            next_state = use_auto ? ee_ctl_pkg::S_POLL : ee_ctl_pkg::S_WAIT_OP;
         end
         ee_ctl_pkg::S_WAIT_OP: begin
            if (wait_end) begin
               next_state = ee_ctl_pkg::S_PGM_OFF;
            end
         end
         ee_ctl_pkg::S_PGM_OFF: next_state = ee_ctl_pkg::S_WAIT_FALL;
         ee_ctl_pkg::S_WAIT_FALL: begin
            if (wait_end) begin
               next_state = ee_ctl_pkg::S_LAT_OFF;
            end
         end
         ee_ctl_pkg::S_LAT_OFF: next_state = ee_ctl_pkg::S_IDLE;
         ee_ctl_pkg::S_POLL: next_state = ee_ctl_pkg::S_POLL_CHK;
         ee_ctl_pkg::S_POLL_CHK: begin
            // Self-timed mode: the enable bit going low replaces the waits.
            next_state = bus.rdata[`CTRL_PGM] ? ee_ctl_pkg::S_POLL :
                         ee_ctl_pkg::S_LAT_OFF;
         end
         ee_ctl_pkg::S_READ: next_state = ee_ctl_pkg::S_IDLE;
         default: next_state = ee_ctl_pkg::S_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state <= ee_ctl_pkg::S_IDLE;
         op <= ee_ctl_pkg::OP_PROG;
         use_auto <= 1'b0;
         tgt_addr <= 16'h0000;
         tgt_data <= `ZERO_BYTE;
      end else begin
         state <= next_state;
         if (req_valid && req_ready) begin
            op <= req_op;
            use_auto <= req_auto;
            tgt_addr <= req_addr;
            tgt_data <= req_data;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wait_cnt <= 24'h000000;
      end else if (next_state == ee_ctl_pkg::S_WAIT_OP && state != next_state) begin
         wait_cnt <= op_cyc;
      end else if (next_state == ee_ctl_pkg::S_WAIT_FALL && state != next_state) begin
         wait_cnt <= FALL_CYC;
      end else if (wait_cnt != 24'h000000) begin
         wait_cnt <= wait_cnt - 24'h000001;
      end
   end

   // ****************************************************************
   // Bus drive, registered from the next state
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wr_en <= 1'b0;
         rd_en <= 1'b0;
         addr <= 16'h0000;
         wdata <= `ZERO_BYTE;
      end else begin
         wr_en <= 1'b0;
         rd_en <= 1'b0;
         addr <= `CTRL_ADDR;
         wdata <= ctrl_base | lat_bit;
         case (next_state)
            ee_ctl_pkg::S_SETUP: wr_en <= 1'b1;
            ee_ctl_pkg::S_DATA: begin
               wr_en <= 1'b1;
               addr <= tgt_addr;
               wdata <= tgt_data;
            end
            ee_ctl_pkg::S_PGM_ON: begin
               wr_en <= 1'b1;
               wdata <= ctrl_base | lat_bit | pgm_bit;
            end
            ee_ctl_pkg::S_PGM_OFF: wr_en <= 1'b1;
            ee_ctl_pkg::S_LAT_OFF: begin
               wr_en <= 1'b1;
               wdata <= ctrl_base;
            end
            ee_ctl_pkg::S_POLL: rd_en <= 1'b1;
            ee_ctl_pkg::S_READ: begin
               rd_en <= 1'b1;
               addr <= req_addr;
            end
            default: wr_en <= 1'b0;
         endcase
      end
   end

   // Read data stands on the bus only one cycle after the strobe is taken,
   // so the answer is picked up one cycle after the read state.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rd_wait <= 1'b0;
         resp_valid <= 1'b0;
         resp_data <= `ZERO_BYTE;
      end else begin
         rd_wait <= state == ee_ctl_pkg::S_READ;
         resp_valid <= rd_wait;
         if (rd_wait) begin
            resp_data <= bus.rdata;
         end
      end
   end
endmodule

/* bench/ee_link_sva.sv */
// Concurrent checks on the bus between the sequencer and the EEPROM controller.
`timescale 1ns/10ps
`include "ee_ctl_consts.svh"
module ee_link_sva (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic timebase_tick,
   input wire logic charge_pump_en,
   input wire logic array_hv,
   input wire logic [7:0] config_shadow,
   input wire logic perm_armed
);
   // ****************************************************************
   // Shadow of the captured target and selected operation
   // ****************************************************************
   logic cap;
   logic [15:0] cap_addr;
   logic [1:0] op_sel;
   wire ctrl_wr = wr_en && addr == `CTRL_ADDR;
   wire tgt_wr = wr_en && ((addr >= `ARRAY_FIRST && addr <= `ARRAY_LAST) || addr == `NV_ADDR);
   wire cap_perm = cap_addr >= `PERM_FIRST && cap_addr <= `PERM_LAST;
   // The target is tracked here so the checks never trust the design's own copy.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cap <= 1'b0;
         cap_addr <= 16'h0000;
         op_sel <= 2'h0;
      end else begin
         if (tgt_wr) begin
            cap <= 1'b1;
            cap_addr <= addr;
         end else if (ctrl_wr && !wdata[`CTRL_LAT] && !charge_pump_en) begin
            cap <= 1'b0;
         end
         if (ctrl_wr && !charge_pump_en) begin
            op_sel <= wdata[`CTRL_RAS_HI:`CTRL_RAS_LO];
         end
      end
   end
   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_pump_rise_cause: assert property ($rose(charge_pump_en) |-> cap &&
      $past(ctrl_wr && wdata[`CTRL_PGM])) else $error("pump started without cause");
   a_pump_fall_cause: assert property ($fell(charge_pump_en) |->
      $past(ctrl_wr && !wdata[`CTRL_PGM]) || $past(timebase_tick))
      else $error("pump stopped without cause");
   a_hv_needs_pump: assert property (array_hv |-> charge_pump_en)
      else $error("array voltage without pump");
   a_no_hv_locked: assert property (array_hv |-> !(perm_armed && (op_sel[1] || cap_perm)))
      else $error("array voltage on locked target");
   a_ctrl_read_bits: assert property (rd_en && addr == `CTRL_ADDR |=>
      rdata[`CTRL_PGM] == $past(charge_pump_en) && rdata[7:5] == 3'h0)
      else $error("control read does not show enable");
   a_latch_sel_kept: assert property (rd_en && addr == `CTRL_ADDR && charge_pump_en |=>
      rdata[`CTRL_LAT] && rdata[`CTRL_RAS_HI:`CTRL_RAS_LO] == op_sel)
      else $error("latch or select changed under voltage");
   a_shadow_reload: assert property (rd_en && addr == `NV_ADDR |->
      ##[1:2] config_shadow == rdata) else $error("shadow not reloaded");
   a_perm_sticky: assert property ($past(perm_armed) |-> perm_armed)
      else $error("permanent protection released");
   c_pump_on: cover property ($rose(charge_pump_en));
   c_blocked_op: cover property (charge_pump_en && !array_hv);
   c_auto_end: cover property ($fell(charge_pump_en) && $past(timebase_tick));
   c_nv_read: cover property (rd_en && addr == `NV_ADDR);
endmodule

/* bench/testbench.sv */
// Self-checking bench: sequencer and controller joined by the bus interface.
`timescale 1ns/10ps
`include "ee_ctl_consts.svh"
module testbench;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic timebase_tick = 1'b0;
   logic [1:0] tick_cnt = 2'h0;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   ee_ctl_pkg::op_t req_op = ee_ctl_pkg::OP_PROG;
   logic req_auto = 1'b0;
   logic [15:0] req_addr = 16'h0000;
   logic [7:0] req_data = 8'h00;
   logic req_ready;
   logic resp_valid;
   logic [7:0] resp_data;
   logic charge_pump_en;
   logic array_hv;
   logic [7:0] config_shadow;
   logic perm_armed;
   int err_count = 0;
   int n_tests = 0;
   ee_bus_if bus (.ref_clk(ref_clk));
   ee_seq_host #(.BYTE_OP_CYC(24'h000014),
      .FALL_CYC(24'h00000A)) i_ee_seq_host (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus),
      .req_valid(req_valid), .req_write(req_write), .req_op(req_op), .req_auto(req_auto),
      .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready),
      .resp_valid(resp_valid), .resp_data(resp_data));
   // Small tick counts keep the self-timed runs short.
   ee_array_ctl #(.BYTE_TICKS(16'h0004), .BLOCK_TICKS(16'h0006), .BULK_TICKS(16'h0008))
      i_ee_array_ctl (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus),
      .timebase_tick(timebase_tick), .charge_pump_en(charge_pump_en), .array_hv(array_hv),
      .config_shadow(config_shadow), .perm_armed(perm_armed));
   ee_link_sva i_ee_link_sva (.ref_clk(ref_clk), .rst_n(rst_n), .wr_en(bus.wr_en),
      .rd_en(bus.rd_en), .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata),
      .timebase_tick(timebase_tick), .charge_pump_en(charge_pump_en), .array_hv(array_hv),
      .config_shadow(config_shadow), .perm_armed(perm_armed));
   always #5 ref_clk = ~ref_clk;
   // One tick every fourth clock.
   always begin
      @(posedge ref_clk);
      #1;
      tick_cnt = tick_cnt + 2'h1;
      timebase_tick = (tick_cnt == 2'h0);
   end
   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic end_of_test();
      if (err_count == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic bail();
      err_count++;
      end_of_test();
   endtask
   task automatic issue(input logic w, input ee_ctl_pkg::op_t o, input logic au,
                        input logic [15:0] a, input logic [7:0] d);
      int n;
      n = 0;
      while (req_ready !== 1'b1) begin
         @(posedge ref_clk);
         #1;
         n++;
         if (n > 5000) bail();
      end
      req_valid = 1'b1;
      req_write = w;
      req_op = o;
      req_auto = au;
      req_addr = a;
      req_data = d;
      @(posedge ref_clk);
      #1;
      req_valid = 1'b0;
   endtask
   task automatic op(input ee_ctl_pkg::op_t o, input logic au, input logic [15:0] a,
                     input logic [7:0] d);
      issue(1'b1, o, au, a, d);
   endtask
   task automatic chk_rd(input string name, input logic [15:0] a, input logic [7:0] exp);
      int n;
      issue(1'b0, ee_ctl_pkg::OP_PROG, 1'b0, a, 8'h00);
      n = 0;
      while (resp_valid !== 1'b1) begin
         @(posedge ref_clk);
         #1;
         n++;
         if (n > 50) bail();
      end
      check(name, resp_data, exp);
   endtask
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (20) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      do_reset();
      check("shadow_at_reset", config_shadow, 8'h70);
      check("perm_at_reset", {7'h00, perm_armed}, 8'h01);
      chk_rd("erased_first", 16'h0800, 8'hFF);
      chk_rd("erased_last", 16'h09FF, 8'hFF);
      chk_rd("unmapped", 16'h0A10, 8'h00);
      op(ee_ctl_pkg::OP_PROG, 1'b0, 16'h0800, 8'hA5);
      chk_rd("prog_manual", 16'h0800, 8'hA5);
      op(ee_ctl_pkg::OP_PROG, 1'b0, 16'h0800, 8'h5A);
      chk_rd("prog_only_clears", 16'h0800, 8'h00);
      op(ee_ctl_pkg::OP_PROG, 1'b1, 16'h0801, 8'h3C);
      chk_rd("prog_auto", 16'h0801, 8'h3C);
      op(ee_ctl_pkg::OP_BYTE_ERASE, 1'b0, 16'h0800, 8'h00);
      chk_rd("byte_erase", 16'h0800, 8'hFF);
      op(ee_ctl_pkg::OP_PROG, 1'b0, 16'h0880, 8'h11);
      op(ee_ctl_pkg::OP_BLOCK_ERASE, 1'b0, 16'h0880, 8'h00);
      chk_rd("block_erase_off", 16'h0880, 8'h11);
      op(ee_ctl_pkg::OP_BULK_ERASE, 1'b1, 16'h0801, 8'h00);
      chk_rd("bulk_erase_off", 16'h0801, 8'h3C);
      op(ee_ctl_pkg::OP_BYTE_ERASE, 1'b1, 16'h0880, 8'h00);
      chk_rd("byte_erase_kept", 16'h0880, 8'hFF);
      op(ee_ctl_pkg::OP_PROG, 1'b0, 16'h08F5, 8'h00);
      chk_rd("perm_range_prog", 16'h08F5, 8'hFF);
      op(ee_ctl_pkg::OP_BYTE_ERASE, 1'b0, 16'h08FF, 8'h00);
      op(ee_ctl_pkg::OP_PROG, 1'b0, 16'h0A01, 8'h00);
      chk_rd("nv_frozen", 16'h0A01, 8'h70);
      chk_rd("shadow_read", 16'h0A02, 8'h70);
      // A second reset must reload the shadow but leave the array alone.
      do_reset();
      check("shadow_again", config_shadow, 8'h70);
      check("perm_again", {7'h00, perm_armed}, 8'h01);
      chk_rd("array_kept", 16'h0801, 8'h3C);
      end_of_test();
   end
endmodule
